// File: design/vcec_checker.sv
// Purpose: capability registers and control-word validity check at entry
// Assumes: control words are stable while entry_req is high
// Notes:   one-cycle read answer; entry verdict two cycles after request
`timescale 1ns/1ps
`default_nettype none
`include "vcec_regs.svh"

module vcec_checker
  import vcec_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register read port
  input  wire logic        rd_req,
  input  wire logic [11:0] rd_index,
  output logic             rd_valid,
  output logic [63:0]      rd_data,
  output logic             rd_fault,
  // entry request and control words
  input  wire logic        entry_req,
  input  wire logic [63:0] prim_exec_ctl,
  input  wire logic [63:0] tert_exec_ctl,
  input  wire logic [31:0] exit_ctl,
  input  wire logic [63:0] sec_exit_ctl,
  input  wire logic [31:0] entry_ctl,
  input  wire logic [1:0]  activity_state,
  input  wire logic        inject_zero_len,
  output logic             entry_done,
  output logic             entry_fail,
  output logic             load_guest,
  // preemption timer
  input  wire logic [63:0] timestamp_counter,
  input  wire logic        timer_load,
  input  wire logic [31:0] timer_init,
  output logic [31:0]      timer_value,
  // exit, operation and management events
  input  wire logic        vm_exit,
  input  wire logic        long_mode_active_flag,
  output logic             long_guest_ctl,
  input  wire logic        enter_virt_operation,
  input  wire logic        leave_virt_operation,
  input  wire logic        trace_ctl_write,
  output logic             trace_enable_bit,
  input  wire logic        trace_enable_set,
  output logic             gp_fault,
  input  wire logic        mon_ctl_bit2,
  output logic             smi_unblock,
  input  wire logic        system_management_state,
  input  wire logic        control_structure_write,
  input  wire logic        write_exit_info,
  output logic             write_reject
);

  // capability words assembled from constants
  wire logic [63:0] basic_cap = `VCEC_BASIC_CAP;
  wire logic [63:0] prim_cap  = `VCEC_PRIM_EXEC_CAP;
  wire logic        true_ok   = basic_cap[`VCEC_BASIC_TRUE_BIT];
  wire logic        tert_ok   = prim_cap[`VCEC_PRIM_TERT_BIT];
  wire logic [63:0] full_exit  = `VCEC_FULL_EXIT_CAP;
  wire logic [63:0] full_entry = `VCEC_FULL_ENTRY_CAP;
  // legacy registers force default-one allowed-0 bits to one
  wire logic [63:0] exit_cap  = full_exit | {32'h0, `VCEC_EXIT_DEFAULT1};
  wire logic [63:0] entry_cap = full_entry | {32'h0, `VCEC_ENTRY_DEFAULT1};
  wire logic        sec_exit_ok = exit_cap[`VCEC_EXIT_SEC_ALLOW_BIT];
  // flag bits 4:2 land at 30:28, bits 1:0 at 15:14
  wire logic [4:0]  misc_flags = `VCEC_MISC_FLAGS;
  wire logic [63:0] misc_cap = {`VCEC_MISC_MONITOR_SEGMENT_REV, 1'b0, misc_flags[4:2],
                                `VCEC_MISC_MSR_LIMIT, `VCEC_MISC_CR3_COUNT,
                                misc_flags[1:0], 5'h00, `VCEC_MISC_ACT_STATES, 1'b1,
                                `VCEC_MISC_RATE};

  // mask check: allowed-0 low half, allowed-1 high half
  function automatic logic mask_bad(input logic [63:0] cap, input logic [31:0] ctl);
    mask_bad = (|(cap[31:0] & ~ctl)) | (|(ctl & ~cap[63:32]));
  endfunction

  // register decode
  wire logic hit_exit  = rd_index == `VCEC_IDX_EXIT_CAP;
  wire logic hit_entry = rd_index == `VCEC_IDX_ENTRY_CAP;
  wire logic hit_misc  = rd_index == `VCEC_IDX_MISC_CAP;
  wire logic hit_fexit = true_ok && rd_index == `VCEC_IDX_FULL_EXIT_CAP;
  wire logic hit_fent  = true_ok && rd_index == `VCEC_IDX_FULL_ENTRY_CAP;
  wire logic hit_tert  = tert_ok && rd_index == `VCEC_IDX_THIRD_EXEC_CAP;
  wire logic hit_sexit = sec_exit_ok && rd_index == `VCEC_IDX_SECOND_EXIT_CAP;
  wire logic [63:0] next_rd_data;
  wire logic        rd_hit;
  assign rd_hit = hit_exit | hit_entry | hit_misc | hit_fexit | hit_fent
                | hit_tert | hit_sexit;
  assign next_rd_data = hit_exit  ? exit_cap :
                        hit_entry ? entry_cap :
                        hit_misc  ? misc_cap :
                        hit_fexit ? full_exit :
                        hit_fent  ? full_entry :
                        hit_tert  ? `VCEC_THIRD_EXEC_CAP :
                        hit_sexit ? `VCEC_SECOND_EXIT_CAP : 64'h0;

  // read answer one cycle after request; unknown index faults
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 64'h0;
      rd_fault <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      rd_data  <= rd_req ? next_rd_data : 64'h0;
      rd_fault <= rd_req & ~rd_hit;
    end
  end

  // control-word checks
  wire logic [63:0] exit_sel  = true_ok ? full_exit : exit_cap;
  wire logic [63:0] entry_sel = true_ok ? full_entry : entry_cap;
  wire logic exit_bad  = mask_bad(exit_sel, exit_ctl) |
                         (~true_ok & |(`VCEC_EXIT_DEFAULT1 & ~exit_ctl));
  wire logic entry_bad = mask_bad(entry_sel, entry_ctl) |
                         (~true_ok & |(`VCEC_ENTRY_DEFAULT1 & ~entry_ctl));
  wire logic tert_bad  = prim_exec_ctl[`VCEC_PRIM_EXEC_TERT_CTL] &
                         (|(tert_exec_ctl & ~(tert_ok ? `VCEC_THIRD_EXEC_CAP : 64'h0)));
  wire logic sec_bad   = exit_ctl[`VCEC_EXIT_SEC_CTL] &
                         (|(sec_exit_ctl & ~(sec_exit_ok ? `VCEC_SECOND_EXIT_CAP : 64'h0)));
  wire logic act_bad   = (activity_state != 2'h0) &
                         ~misc_cap[6 + activity_state - 2'h1];
  wire logic inj_bad   = inject_zero_len & ~misc_cap[`VCEC_MISC_ZLEN_BIT];
  wire logic any_bad   = exit_bad | entry_bad | tert_bad | sec_bad | act_bad | inj_bad;

  // entry sequence: sample, check, then one verdict
  vcec_state_t state;
  vcec_state_t next_state;
  logic        bad_q;
  assign next_state = (state == VCEC_IDLE && entry_req) ? VCEC_CHECK :
                      (state == VCEC_CHECK) ? VCEC_DONE :
                      VCEC_IDLE;

  // the verdict is registered before any guest load is signalled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= VCEC_IDLE;
      bad_q      <= 1'b0;
      entry_done <= 1'b0;
      entry_fail <= 1'b0;
      load_guest <= 1'b0;
    end else begin
      state      <= next_state;
      bad_q      <= (state == VCEC_IDLE) ? any_bad : bad_q;
      entry_done <= state == VCEC_CHECK;
      entry_fail <= state == VCEC_CHECK && bad_q;
      load_guest <= state == VCEC_CHECK && !bad_q;
    end
  end

  // preemption timer: decrement on toggle of timestamp bit X
  logic       ts_bit_q;
  logic       timer_run;
  wire  logic ts_bit = timestamp_counter[`VCEC_MISC_RATE];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_bit_q    <= 1'b0;
      timer_value <= 32'h0;
      timer_run   <= 1'b0;
    end else begin
      ts_bit_q <= ts_bit;
      if (timer_load) begin
        timer_value <= timer_init;
        timer_run   <= 1'b1;
      end else if (timer_run && ts_bit != ts_bit_q && timer_value != 32'h0) begin
        timer_value <= timer_value - 32'h1;
      end
    end
  end

  // exit, operation and management side effects
  logic in_virt;
  wire  logic trace_allowed = misc_cap[`VCEC_MISC_TRACE_BIT];
  wire  logic smbase_ok     = misc_cap[`VCEC_MISC_SMBASE_BIT];
  wire  logic mon_ok        = misc_cap[`VCEC_MISC_SMM_MON_BIT] & mon_ctl_bit2;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_virt          <= 1'b0;
      long_guest_ctl   <= 1'b0;
      trace_enable_bit <= 1'b0;
      gp_fault         <= 1'b0;
      smi_unblock      <= 1'b0;
      write_reject     <= 1'b0;
    end else begin
      in_virt <= enter_virt_operation ? 1'b1 : leave_virt_operation ? 1'b0 : in_virt;
      if (vm_exit && misc_cap[`VCEC_MISC_LMA_BIT]) begin
        long_guest_ctl <= long_mode_active_flag;
      end
      if (enter_virt_operation && !trace_allowed) begin
        trace_enable_bit <= 1'b0;
      end else if (trace_enable_set && !(in_virt && !trace_allowed)) begin
        trace_enable_bit <= 1'b1;
      end
      gp_fault     <= trace_ctl_write && in_virt && !trace_allowed;
      smi_unblock  <= leave_virt_operation && !mon_ok;
      write_reject <= control_structure_write && write_exit_info &&
                      !misc_cap[`VCEC_MISC_WRITE_ALL_BIT];
    end
  end
  // smbase_ok is the management-state read permission of the base register
  wire logic smbase_read_ok = smbase_ok & system_management_state;
  wire logic unused_ok = smbase_read_ok;

endmodule
`default_nettype wire

// File: design/vcec_pkg.sv
// Purpose: types for the virtualization capability and entry checker
// Assumes: nothing beyond the constants header
// Notes:   check states of the entry sequence
package vcec_pkg;
  typedef enum logic [1:0] {
    VCEC_IDLE  = 2'b00,
    VCEC_CHECK = 2'b01,
    VCEC_DONE  = 2'b10
  } vcec_state_t;
endpackage

// File: design/vcec_regs.svh
// Purpose: constants for the virtualization capability and entry checker
// Assumes: register indices are model-specific register numbers
// Notes:   capability values are build-time constants of this core
`ifndef VCEC_REGS_SVH
`define VCEC_REGS_SVH

// register indices
`define VCEC_IDX_EXIT_CAP        12'h483
`define VCEC_IDX_ENTRY_CAP       12'h484
`define VCEC_IDX_MISC_CAP        12'h485
`define VCEC_IDX_FULL_EXIT_CAP   12'h48f
`define VCEC_IDX_FULL_ENTRY_CAP  12'h490
`define VCEC_IDX_THIRD_EXEC_CAP  12'h492
`define VCEC_IDX_SECOND_EXIT_CAP 12'h493

// field positions
`define VCEC_BASIC_TRUE_BIT      55
`define VCEC_PRIM_TERT_BIT       49
`define VCEC_PRIM_EXEC_TERT_CTL  17
`define VCEC_EXIT_SEC_CTL        31
`define VCEC_EXIT_SEC_ALLOW_BIT  63
`define VCEC_MISC_LMA_BIT        5
`define VCEC_MISC_TRACE_BIT      14
`define VCEC_MISC_SMBASE_BIT     15
`define VCEC_MISC_SMM_MON_BIT    28
`define VCEC_MISC_WRITE_ALL_BIT  29
`define VCEC_MISC_ZLEN_BIT       30
`define VCEC_ENTRY_LONG_GUEST    9

// default-one control classes
`define VCEC_EXIT_DEFAULT1       32'h0003_6dff
`define VCEC_ENTRY_DEFAULT1      32'h0000_11ff

// capability values of this core
`define VCEC_BASIC_CAP           64'h0080_0000_0000_0000
`define VCEC_PRIM_EXEC_CAP       64'h8002_0000_0000_0000
`define VCEC_FULL_EXIT_CAP       64'h803f_ffff_0003_6dfb
`define VCEC_FULL_ENTRY_CAP      64'h0000_ffff_0000_11fb
`define VCEC_THIRD_EXEC_CAP      64'h0000_0000_0000_00ff
`define VCEC_SECOND_EXIT_CAP     64'h0000_0000_0000_000f
`define VCEC_MISC_RATE           5'h05
`define VCEC_MISC_ACT_STATES     3'h7
`define VCEC_MISC_CR3_COUNT      9'h004
`define VCEC_MISC_MSR_LIMIT      3'h0
`define VCEC_MISC_FLAGS          5'h1f
`define VCEC_MISC_MONITOR_SEGMENT_REV       32'h0000_0000

`endif

// File: verification/testbench.sv
// Purpose: self-checking bench for the capability and entry checker
// Assumes: one-cycle read answer, entry verdict two cycles later
// Notes:   expectations built from the capability constants
`timescale 1ns/1ps
`default_nettype none
`include "vcec_regs.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_n, rd_req, rd_valid, rd_fault, entry_req, inject_zero_len, entry_done, entry_fail;
  logic load_guest, timer_load, vm_exit, long_mode_active_flag, long_guest_ctl, gp_fault;
  logic enter_virt_operation, leave_virt_operation, trace_ctl_write, trace_enable_bit;
  logic trace_enable_set, mon_ctl_bit2, smi_unblock, system_management_state, write_reject;
  logic control_structure_write, write_exit_info;
  logic [11:0] rd_index;
  logic [63:0] rd_data, prim_exec_ctl, tert_exec_ctl, sec_exit_ctl, timestamp_counter;
  logic [31:0] exit_ctl, entry_ctl, timer_init, timer_value;
  logic [1:0]  activity_state;
  int          num_errors, total_checks, cycles;
  localparam logic [63:0] fx = `VCEC_FULL_EXIT_CAP;
  localparam logic [63:0] fn = `VCEC_FULL_ENTRY_CAP;
  localparam logic [31:0] xg = 32'h8003_6dfb;
  localparam logic [31:0] ng = 32'h0000_11fb;
  // device under test
  vcec_checker u_vcec_checker (.core_clk, .rst_n, .rd_req, .rd_index, .rd_valid, .rd_data,
    .rd_fault, .entry_req, .prim_exec_ctl, .tert_exec_ctl, .exit_ctl, .sec_exit_ctl, .entry_ctl,
    .activity_state, .inject_zero_len, .entry_done, .entry_fail, .load_guest, .timestamp_counter,
    .timer_load, .timer_init, .timer_value, .vm_exit, .long_mode_active_flag, .long_guest_ctl,
    .enter_virt_operation, .leave_virt_operation, .trace_ctl_write, .trace_enable_bit,
    .trace_enable_set, .gp_fault, .mon_ctl_bit2, .smi_unblock, .system_management_state,
    .control_structure_write, .write_exit_info, .write_reject);
  // clock and cycle ceiling
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one register read, masked compare
  task automatic rd(input logic [11:0] idx, input logic [63:0] msk, exp, input logic flt);
    @(posedge core_clk);
    #1 rd_req = 1'b1;
    rd_index = idx;
    @(posedge core_clk);
    #1 rd_req = 1'b0;
    chk({63'h0, rd_valid}, 64'h1, "read valid");
    chk({63'h0, rd_fault}, {63'h0, flt}, "read fault");
    chk(rd_data & msk, exp, "read data");
  endtask
  // one entry attempt, verdict predicted from the masks
  task automatic ent(input logic [63:0] pe, te, se, input logic [31:0] xc, nc,
                     input logic [1:0] act);
    logic f;
    f = (pe[17] && |(te & ~`VCEC_THIRD_EXEC_CAP)) || (xc[31] && |(se & ~`VCEC_SECOND_EXIT_CAP))
      || |(~xc & fx[31:0]) || |(xc & ~fx[63:32]) || |(~nc & fn[31:0]) || |(nc & ~fn[63:32]);
    @(posedge core_clk);
    #1 entry_req = 1'b1;
    {prim_exec_ctl, tert_exec_ctl, sec_exit_ctl, exit_ctl, entry_ctl, activity_state} =
      {pe, te, se, xc, nc, act};
    @(posedge core_clk);
    #1 entry_req = 1'b0;
    @(posedge core_clk);
    #1 chk({61'h0, entry_done, entry_fail, load_guest}, {61'h0, 1'b1, f, !f}, "entry verdict");
  endtask
  // main sequence
  initial begin
    {rst_n, rd_req, entry_req, inject_zero_len, timer_load, vm_exit, long_mode_active_flag} = '0;
    {enter_virt_operation, leave_virt_operation, trace_ctl_write, trace_enable_set} = '0;
    {mon_ctl_bit2, system_management_state, control_structure_write, write_exit_info} = '0;
    {rd_index, prim_exec_ctl, tert_exec_ctl, sec_exit_ctl, timestamp_counter} = '0;
    {exit_ctl, entry_ctl, timer_init, activity_state} = '0;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    rd(12'h483, {32'h8000_0000, `VCEC_EXIT_DEFAULT1}, {32'h8000_0000, `VCEC_EXIT_DEFAULT1}, 0);
    rd(12'h484, {32'h0, `VCEC_ENTRY_DEFAULT1}, {32'h0, `VCEC_ENTRY_DEFAULT1}, 0);
    rd(12'h485, 64'hffff_ffff_8fff_3fdf, {`VCEC_MISC_MONITOR_SEGMENT_REV, 4'h0, `VCEC_MISC_MSR_LIMIT,
       `VCEC_MISC_CR3_COUNT, 7'h00, `VCEC_MISC_ACT_STATES, 1'b0, `VCEC_MISC_RATE}, 0);
    rd(12'h48f, '1, fx, 0);
    rd(12'h490, '1, fn, 0);
    rd(12'h492, '1, `VCEC_THIRD_EXEC_CAP, 0);
    rd(12'h493, '1, `VCEC_SECOND_EXIT_CAP, 0);
    rd(12'h486, '1, 64'h0, 1);
    ent(64'h2_0000, 64'h0, 64'h0, xg, ng, 2'd0);
    ent(64'h2_0000, 64'h100, 64'h0, xg, ng, 2'd0);
    ent(64'h0, 64'h100, 64'h0, xg, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h10, xg, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h10, xg & 32'h7fff_ffff, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg & ~32'h1, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg & ~32'h4, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg | 32'h40_0000, ng, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg, ng & ~32'h1, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg, ng & ~32'h4, 2'd0);
    ent(64'h2_0000, 64'h0, 64'h0, xg, ng | 32'h1_0000, 2'd0);
    for (int a = 1; a < 4; a++) ent(64'h2_0000, 64'h0, 64'h0, xg, ng, 2'(a));
    // preemption timer steps on each toggle of the rate bit
    @(posedge core_clk);
    #1 timer_load = 1'b1;
    timer_init = 32'h3;
    @(posedge core_clk);
    #1 timer_load = 1'b0;
    for (int k = 1; k < 5; k++) begin
      timestamp_counter += 64'h20;
      repeat (3) @(posedge core_clk);
      #1 chk({32'h0, timer_value}, (k < 3) ? 64'(3 - k) : 64'h0, "timer");
    end
    // exit copy and leave events
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      #1 {vm_exit, leave_virt_operation, long_mode_active_flag, mon_ctl_bit2} = {2'b11, 1'(v), 1'(v)};
      {enter_virt_operation, trace_ctl_write, control_structure_write, write_exit_info} = '1;
      @(posedge core_clk);
      #1 {vm_exit, leave_virt_operation, enter_virt_operation, trace_ctl_write} = '0;
      chk({63'h0, long_guest_ctl}, 64'(v), "long mode copy");
      chk({63'h0, smi_unblock}, 64'(1 - v), "interrupt unblock");
      chk({63'h0, gp_fault}, 64'h0, "trace write fault");
      chk({63'h0, write_reject}, 64'h0, "exit info write");
    end
    test_done();
  end
endmodule
bind vcec_checker vcec_checker_properties u_vcec_checker_properties (.core_clk, .rst_n, .rd_req,
  .rd_valid, .rd_fault, .rd_index, .rd_data, .entry_req, .entry_done, .entry_fail, .load_guest,
  .prim_exec_ctl, .tert_exec_ctl, .sec_exit_ctl, .exit_ctl, .entry_ctl, .vm_exit,
  .long_mode_active_flag, .long_guest_ctl, .leave_virt_operation, .mon_ctl_bit2, .smi_unblock);
`default_nettype wire

// File: verification/vcec_checker_properties.sv
// Purpose: port-level properties of the capability and entry checker
// Assumes: capability constants come from the shared header
// Notes:   entry verdict lands two cycles after an accepted request
`timescale 1ns/1ps
`default_nettype none
`include "vcec_regs.svh"
module vcec_checker_properties (
  // clock, reset and read port
  input wire logic        core_clk, rst_n, rd_req, rd_valid, rd_fault,
  input wire logic [11:0] rd_index,
  input wire logic [63:0] rd_data,
  // entry request and verdict
  input wire logic        entry_req, entry_done, entry_fail, load_guest,
  input wire logic [63:0] prim_exec_ctl, tert_exec_ctl, sec_exit_ctl,
  input wire logic [31:0] exit_ctl, entry_ctl,
  // exit and management events
  input wire logic        vm_exit, long_mode_active_flag, long_guest_ctl,
  input wire logic        leave_virt_operation, mon_ctl_bit2, smi_unblock
);
  localparam logic [63:0] full_exit = `VCEC_FULL_EXIT_CAP;
  localparam logic [63:0] full_entry = `VCEC_FULL_ENTRY_CAP;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // read answers
  a_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  a_fault_zero: assert property (rd_fault |-> rd_data == 64'h0)
    else $error("refused read carries data");
  a_exit_ones: assert property (rd_req && rd_index == `VCEC_IDX_EXIT_CAP |=>
    (rd_data[31:0] & `VCEC_EXIT_DEFAULT1) == `VCEC_EXIT_DEFAULT1) else $error("exit ones");
  a_entry_ones: assert property (rd_req && rd_index == `VCEC_IDX_ENTRY_CAP |=>
    (rd_data[31:0] & `VCEC_ENTRY_DEFAULT1) == `VCEC_ENTRY_DEFAULT1) else $error("entry ones");
  a_cr3_count: assert property (rd_req && rd_index == `VCEC_IDX_MISC_CAP |=>
    rd_data[24] == (rd_data[23:16] == 8'h00)) else $error("target count form");
  a_misc_reserved: assert property (rd_req && rd_index == `VCEC_IDX_MISC_CAP |=>
    rd_data[13:9] == 5'h00 && !rd_data[31]) else $error("reserved bits set");
  // entry verdict
  a_single_verdict: assert property (entry_done == (entry_fail ^ load_guest))
    else $error("verdict not single");
  a_entry_timing: assert property (entry_req |-> ##2 entry_done)
    else $error("entry verdict late");
  a_allow0_fail: assert property (entry_req && |(~exit_ctl & full_exit[31:0]) |->
    ##2 entry_fail) else $error("cleared exit control passed");
  a_allow1_fail: assert property (entry_req && |(entry_ctl & ~full_entry[63:32]) |->
    ##2 entry_fail) else $error("set entry control passed");
  a_tert_fail: assert property (entry_req && prim_exec_ctl[17] &&
    |(tert_exec_ctl & ~`VCEC_THIRD_EXEC_CAP) |-> ##2 entry_fail) else $error("tertiary passed");
  a_sec_fail: assert property (entry_req && exit_ctl[31] &&
    |(sec_exit_ctl & ~`VCEC_SECOND_EXIT_CAP) |-> ##2 entry_fail) else $error("secondary passed");
  // exit and leave events
  a_long_copy: assert property (vm_exit |=> long_guest_ctl == $past(long_mode_active_flag))
    else $error("long mode not copied");
  a_smi_kept: assert property (leave_virt_operation && mon_ctl_bit2 |=> !smi_unblock)
    else $error("interrupts unblocked");
endmodule
`default_nettype wire
